// >>> pkg/flash_part_defs.vh
`ifndef FLASH_PART_DEFS_VH
`define FLASH_PART_DEFS_VH
// Config word addresses (byte address in flash space)
`define CFG_WORD0_ADDR      22'h30_0000
`define CFG_WORD1_ADDR      22'h30_0004
`define CFG_SPACE_BIT       21
`define CFG_IDX_W           7
// Boot configuration word 0 fields
`define CFG0_DATA_REGION_ENABLE_FIELD_N_BIT     0
`define CFG0_UNLOCK_BIT     1
`define CFG0_LDR_EN_BIT     2
`define CFG0_BOOT_SRC_BIT   7
`define CFG0_BROWNOUT_BIT   23
// Boot configuration word 1 fields
`define CFG1_BASE_MSB       19
`define CFG1_SECTOR_LSB     10
// Geometry
`define MAIN_SIZE_BYTES     20'h2_3400
`define LDR_SIZE_BYTES      20'h0_1000
`define LDR_BASE_ADDR       22'h10_0000
`define SECTOR_WORDS        8'h00
`define SECTOR_WORDS_W      8
`define WORD_ADDR_W         16
`define MAIN_WORDS          16'h8D00
`define TOTAL_WORDS         16'h9100
// Values
`define ERASED_WORD         32'hFFFF_FFFF
`define DEVICE_ID_VALUE     32'h0000_0001
`define ID_ADDR             22'h3F_FFFC
// Commands
`define CMD_READ            2'h0
`define CMD_PROGRAM         2'h1
`define CMD_ERASE           2'h2
`define CMD_NONE            2'h3
// Reset images of config words
`define CFG0_RESET          32'hFFFF_FFFF
`define CFG1_RESET          32'h0000_0000
`endif

// >>> rtl/flash_word_mem.v
`timescale 1ns/10ps
`include "flash_part_defs.vh"
module flash_word_mem (
   // Clock
   input  wire                      core_clk_i,
   // Access
   input  wire                      wr_i,
   input  wire [`WORD_ADDR_W-1:0]   addr_i,
   input  wire [31:0]               wdata_i,
   output reg  [31:0]               rdata_o
);
   reg [31:0] mem [0:`TOTAL_WORDS-1];
   always @(posedge core_clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end
endmodule // flash_word_mem

// >>> rtl/flash_partition_boot_config.v
`timescale 1ns/10ps
`include "flash_part_defs.vh"
module flash_partition_boot_config (
   // Clock and reset
   input  wire          core_clk_i,
   input  wire          reset_i,
   // Self-programming command path
   input  wire          cmd_valid_i,
   input  wire [1:0]    cmd_op_i,
   input  wire [21:0]   cmd_addr_i,
   input  wire [31:0]   cmd_wdata_i,
   output wire          cmd_ready_o,
   output reg           cmd_done_o,
   output reg           cmd_fail_o,
   output reg  [31:0]   cmd_rdata_o,
   // External programming read path
   input  wire          ext_rd_i,
   input  wire [21:0]   ext_addr_i,
   output reg           ext_done_o,
   output reg  [31:0]   ext_rdata_o,
   // Brownout
   input  wire          brownout_detect_i,
   output wire          brownout_enable_o,
   output wire          brownout_nmi_o,
   // Decoded configuration
   output wire          config_valid_o,
   output wire          boot_from_program_o,
   output wire          flash_secured_o,
   output wire          debug_enable_o,
   output wire          data_region_enable_o,
   output wire          loader_region_on_o,
   output wire [19:0]   data_base_readback_o,
   output wire [19:0]   program_region_end_o
);
   localparam ST_LOAD0 = 3'd0;
   localparam ST_LOAD1 = 3'd1;
   localparam ST_IDLE  = 3'd2;
   localparam ST_RD    = 3'd3;
   localparam ST_PROG  = 3'd4;
   localparam ST_ERASE = 3'd5;
   localparam ST_EXTRD = 3'd6;

   reg  [2:0]                 state_q;
   reg  [31:0]                boot_config_word0_q;
   reg  [31:0]                boot_config_word1_q;
   reg  [31:0]                cfg_mem [0:(1<<`CFG_IDX_W)-1];
   reg  [31:0]                cfg_rd_q;
   reg  [`WORD_ADDR_W-1:0]    op_addr_q;
   reg  [`SECTOR_WORDS_W-1:0] erase_cnt_q;
   reg  [31:0]                wdata_q;
   reg                        prog_rd_q;
   reg                        op_cfg_q;
   reg                        ext_id_q;
   reg                        ext_hide_q;
   reg                        bo_s1_q;
   reg                        bo_s2_q;
   reg                        mem_wr;
   reg  [`WORD_ADDR_W-1:0]    mem_addr;
   reg  [31:0]                mem_wdata;
   wire [31:0]                mem_rdata;
   wire [19:0]                base_aligned;
   wire [19:0]                main_limit;
   wire                       addr_ok;
   wire                       cfg_hit;
   wire [`CFG_IDX_W-1:0]      cfg_idx;
   wire [`WORD_ADDR_W-1:0]    cmd_word;
   integer                    cfg_i;

   // Configuration decode
   assign config_valid_o       = (state_q != ST_LOAD0) && (state_q != ST_LOAD1);
   assign data_region_enable_o = ~boot_config_word0_q[`CFG0_DATA_REGION_ENABLE_FIELD_N_BIT];
   assign flash_secured_o      = ~boot_config_word0_q[`CFG0_UNLOCK_BIT];
   assign debug_enable_o       = config_valid_o & ~flash_secured_o;
   assign loader_region_on_o   = boot_config_word0_q[`CFG0_LDR_EN_BIT];
   assign boot_from_program_o  = boot_config_word0_q[`CFG0_BOOT_SRC_BIT];
   assign brownout_enable_o    = config_valid_o &
                                 boot_config_word0_q[`CFG0_BROWNOUT_BIT];
   assign brownout_nmi_o       = brownout_enable_o & bo_s2_q;
   // Sector-aligned base; low ten bits forced to zero
   assign base_aligned = {boot_config_word1_q[`CFG1_BASE_MSB:`CFG1_SECTOR_LSB],
                          {`CFG1_SECTOR_LSB{1'b0}}};
   // Loader off folds its 4KB into main memory
   assign main_limit = loader_region_on_o ? `MAIN_SIZE_BYTES
                       : (`MAIN_SIZE_BYTES + `LDR_SIZE_BYTES);
   assign data_base_readback_o = data_region_enable_o ? base_aligned : main_limit;
   assign program_region_end_o = data_region_enable_o ? base_aligned
                                 : main_limit;

   // Address decode for self-programming path
   assign cfg_hit  = cmd_addr_i[`CFG_SPACE_BIT];
   // External reads steer the config index whenever ext_rd_i is high, in any state
   assign cfg_idx  = ext_rd_i ? ext_addr_i[`CFG_IDX_W+1:2] : cmd_addr_i[`CFG_IDX_W+1:2];
   assign cmd_word = cmd_addr_i[`WORD_ADDR_W+1:2];
   // Bit 20 addresses lie above main memory, never aliased
   assign addr_ok  = cfg_hit | (~cmd_addr_i[20] & (cmd_addr_i[19:0] < main_limit));
   assign cmd_ready_o = (state_q == ST_IDLE);

   always @(posedge core_clk_i) begin
      bo_s1_q <= brownout_detect_i;
      bo_s2_q <= bo_s1_q;
   end

   // Fresh part ships with config space erased
   initial begin
      for (cfg_i = 0; cfg_i < (1 << `CFG_IDX_W); cfg_i = cfg_i + 1) begin
         cfg_mem[cfg_i] = `ERASED_WORD;
      end
   end

   // Config space storage
   always @(posedge core_clk_i) begin
      cfg_rd_q <= cfg_mem[cfg_idx];
      if (cmd_ready_o && cmd_valid_i && !ext_rd_i && cfg_hit) begin
         if (cmd_op_i == `CMD_PROGRAM) begin
            cfg_mem[cfg_idx] <= cfg_mem[cfg_idx] & cmd_wdata_i;
         end else if (cmd_op_i == `CMD_ERASE) begin
            cfg_mem[cfg_idx] <= `ERASED_WORD;
         end
      end
   end

   // Main array port steering
   always @* begin
      mem_wr    = 1'b0;
      mem_addr  = op_addr_q;
      mem_wdata = mem_rdata & wdata_q;
      case (state_q)
         ST_IDLE: begin
            mem_addr = ext_rd_i ? ext_addr_i[`WORD_ADDR_W+1:2] : cmd_word;
         end
         ST_PROG: begin
            mem_wr = prog_rd_q;
         end
         ST_ERASE: begin
            mem_addr  = {op_addr_q[`WORD_ADDR_W-1:`SECTOR_WORDS_W], erase_cnt_q};
            mem_wr    = 1'b1;
            mem_wdata = `ERASED_WORD;
         end
         default: begin
            mem_addr = op_addr_q;
         end
      endcase
   end

   flash_word_mem u_mem (
      .core_clk_i (core_clk_i),
      .wr_i       (mem_wr),
      .addr_i     (mem_addr),
      .wdata_i    (mem_wdata),
      .rdata_o    (mem_rdata)
   );

   always @(posedge core_clk_i) begin
      if (reset_i) begin
         state_q             <= ST_LOAD0;
         boot_config_word0_q <= `CFG0_RESET;
         boot_config_word1_q <= `CFG1_RESET;
         op_addr_q           <= {`WORD_ADDR_W{1'b0}};
         erase_cnt_q         <= {`SECTOR_WORDS_W{1'b0}};
         wdata_q             <= 32'h0000_0000;
         prog_rd_q           <= 1'b0;
         op_cfg_q            <= 1'b0;
         ext_id_q            <= 1'b0;
         ext_hide_q          <= 1'b0;
         cmd_done_o          <= 1'b0;
         cmd_fail_o          <= 1'b0;
         cmd_rdata_o         <= 32'h0000_0000;
         ext_done_o          <= 1'b0;
         ext_rdata_o         <= 32'h0000_0000;
      end else begin
         cmd_done_o <= 1'b0;
         cmd_fail_o <= 1'b0;
         ext_done_o <= 1'b0;
         case (state_q)
            ST_LOAD0: begin
               boot_config_word0_q <= cfg_mem[0];
               state_q             <= ST_LOAD1;
            end
            ST_LOAD1: begin
               boot_config_word1_q <= cfg_mem[1];
               state_q             <= ST_IDLE;
            end
            ST_IDLE: begin
               op_addr_q <= cmd_word;
               wdata_q   <= cmd_wdata_i;
               prog_rd_q <= 1'b0;
               op_cfg_q  <= cfg_hit;
               if (ext_rd_i) begin
                  op_addr_q  <= ext_addr_i[`WORD_ADDR_W+1:2];
                  op_cfg_q   <= ext_addr_i[`CFG_SPACE_BIT];
                  ext_id_q   <= (ext_addr_i == `ID_ADDR);
                  ext_hide_q <= flash_secured_o & ~ext_addr_i[`CFG_SPACE_BIT]
                                & (ext_addr_i != `ID_ADDR);
                  state_q    <= ST_EXTRD;
               end else if (cmd_valid_i) begin
                  // Commands are the only path that writes the main array
                  if (!addr_ok || cmd_op_i == `CMD_NONE) begin
                     cmd_fail_o <= 1'b1;
                     cmd_done_o <= 1'b1;
                  end else if (cmd_op_i == `CMD_READ) begin
                     state_q <= ST_RD;
                  end else if (cfg_hit) begin
                     cmd_done_o <= 1'b1;
                  end else if (cmd_op_i == `CMD_PROGRAM) begin
                     state_q <= ST_PROG;
                  end else begin
                     erase_cnt_q <= `SECTOR_WORDS;
                     state_q     <= ST_ERASE;
                  end
               end
            end
            ST_RD: begin
               cmd_rdata_o <= op_cfg_q ? cfg_rd_q : mem_rdata;
               cmd_done_o  <= 1'b1;
               state_q     <= ST_IDLE;
            end
            ST_PROG: begin
               prog_rd_q <= 1'b1;
               if (prog_rd_q) begin
                  cmd_done_o <= 1'b1;
                  state_q    <= ST_IDLE;
               end
            end
            ST_ERASE: begin
               erase_cnt_q <= erase_cnt_q + 1'b1;
               if (&erase_cnt_q) begin
                  cmd_done_o <= 1'b1;
                  state_q    <= ST_IDLE;
               end
            end
            ST_EXTRD: begin
               if (ext_id_q) begin
                  ext_rdata_o <= `DEVICE_ID_VALUE;
               end else if (ext_hide_q) begin
                  ext_rdata_o <= `ERASED_WORD;
               end else if (op_cfg_q) begin
                  ext_rdata_o <= cfg_rd_q;
               end else begin
                  ext_rdata_o <= mem_rdata;
               end
               ext_done_o <= 1'b1;
               state_q    <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // flash_partition_boot_config

// >>> sim/flash_partition_boot_config_props.sv
`timescale 1ns/10ps
`include "flash_part_defs.vh"
module flash_partition_boot_config_props (
   // Clock and reset
   input wire        core_clk_i,
   input wire        reset_i,
   // Command path
   input wire        cmd_valid_i,
   input wire [1:0]  cmd_op_i,
   input wire [21:0] cmd_addr_i,
   input wire        cmd_ready_o,
   input wire        cmd_done_o,
   input wire        cmd_fail_o,
   input wire        ext_rd_i,
   // Brownout and decode
   input wire        brownout_detect_i,
   input wire        brownout_enable_o,
   input wire        brownout_nmi_o,
   input wire        config_valid_o,
   input wire        flash_secured_o,
   input wire        debug_enable_o,
   input wire        data_region_enable_o,
   input wire        loader_region_on_o,
   input wire [19:0] data_base_readback_o,
   input wire [19:0] program_region_end_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // Command taken; taken with main address below MAIN_SIZE_BYTES
   wire take    = cmd_valid_i && cmd_ready_o && !ext_rd_i;
   wire main_ok = take && (cmd_addr_i < {2'b00, `MAIN_SIZE_BYTES});
   AST_READ: assert property (main_ok && cmd_op_i == `CMD_READ |-> ##2 cmd_done_o)
      else $error("read answer not on time");
   AST_PROG: assert property (main_ok && cmd_op_i == `CMD_PROGRAM |-> ##3 cmd_done_o && !cmd_fail_o)
      else $error("program answer not on time");
   AST_ERASE: assert property (main_ok && cmd_op_i == `CMD_ERASE
      |-> ##1 (!cmd_done_o)[*8] ##249 cmd_done_o && !cmd_fail_o) else $error("erase time wrong");
   AST_NONE: assert property (take && cmd_op_i == `CMD_NONE |-> ##1 cmd_done_o && cmd_fail_o)
      else $error("empty op not refused");
   AST_FAIL: assert property (cmd_fail_o |-> cmd_done_o)
      else $error("fail without done");
   AST_BOD_ON: assert property ((brownout_enable_o && brownout_detect_i)[*4] |-> brownout_nmi_o)
      else $error("brownout nmi missing");
   AST_BOD_OFF: assert property (config_valid_o && !brownout_enable_o |-> !brownout_nmi_o)
      else $error("nmi while brownout disabled");
   AST_DEBUG: assert property (debug_enable_o == (config_valid_o && !flash_secured_o))
      else $error("debug gate wrong");
   AST_SPLIT: assert property (config_valid_o && data_region_enable_o
      |-> program_region_end_o == data_base_readback_o && data_base_readback_o[9:0] == 10'h000)
      else $error("partition split wrong");
   AST_FULL: assert property (config_valid_o && !data_region_enable_o |-> program_region_end_o ==
      (loader_region_on_o ? `MAIN_SIZE_BYTES : `MAIN_SIZE_BYTES + `LDR_SIZE_BYTES))
      else $error("program region size wrong");
endmodule // flash_partition_boot_config_props
bind flash_partition_boot_config flash_partition_boot_config_props u_props (
   .core_clk_i           (core_clk_i),
   .reset_i              (reset_i),
   .cmd_valid_i          (cmd_valid_i),
   .cmd_op_i             (cmd_op_i),
   .cmd_addr_i           (cmd_addr_i),
   .cmd_ready_o          (cmd_ready_o),
   .cmd_done_o           (cmd_done_o),
   .cmd_fail_o           (cmd_fail_o),
   .ext_rd_i             (ext_rd_i),
   .brownout_detect_i    (brownout_detect_i),
   .brownout_enable_o    (brownout_enable_o),
   .brownout_nmi_o       (brownout_nmi_o),
   .config_valid_o       (config_valid_o),
   .flash_secured_o      (flash_secured_o),
   .debug_enable_o       (debug_enable_o),
   .data_region_enable_o (data_region_enable_o),
   .loader_region_on_o   (loader_region_on_o),
   .data_base_readback_o (data_base_readback_o),
   .program_region_end_o (program_region_end_o)
);

// >>> sim/fw_model.sv
`timescale 1ns/10ps
`include "flash_part_defs.vh"
module fw_model (
   // Clock
   input  wire        core_clk_i,
   // Command answer
   input  wire        ready_i,
   input  wire        done_i,
   input  wire        fail_i,
   input  wire [31:0] rdata_i,
   // Command request
   output reg         valid_o = 1'b0,
   output reg  [1:0]  op_o = `CMD_NONE,
   output reg  [21:0] addr_o = 22'h0,
   output reg  [31:0] wdata_o = 32'h0
);
   // One word command, held until taken
   task automatic run(input [1:0] o, input [21:0] a, input [31:0] d, output [31:0] r,
                      output f);
      integer n;
      @(posedge core_clk_i);
      valid_o <= 1'b1;
      op_o    <= o;
      addr_o  <= a;
      wdata_o <= d;
      @(negedge core_clk_i);
      for (n = 0; n < 400 && ready_i !== 1'b1; n++) @(negedge core_clk_i);
      @(posedge core_clk_i);
      valid_o <= 1'b0;
      addr_o  <= ~a;
      wdata_o <= ~d;
      @(negedge core_clk_i);
      for (n = 0; n < 400 && done_i !== 1'b1; n++) @(negedge core_clk_i);
      r = rdata_i;
      f = fail_i;
   endtask
endmodule // fw_model

// >>> sim/tb_flash_partition_boot_config.sv
`timescale 1ns/10ps
`include "flash_part_defs.vh"
module tb_flash_partition_boot_config;
   logic        core_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        ext_rd_i = 1'b0;
   logic [21:0] ext_addr_i = 22'h0;
   logic        bod_i = 1'b0;
   wire         valid, ready, done, fail, ext_done, bod_en, nmi, cfg_ok;
   wire         boot_prog, secured, dbg_en, data_en, ldr_on;
   wire  [1:0]  op;
   wire  [21:0] addr;
   wire  [31:0] wdata, rdata, ext_rdata;
   wire  [19:0] base, prog_end;
   integer      fails = 0;
   integer      num_checks = 0;
   always #5 core_clk_i = ~core_clk_i;
   flash_partition_boot_config u_dut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .cmd_valid_i(valid), .cmd_op_i(op),
      .cmd_addr_i(addr), .cmd_wdata_i(wdata), .cmd_ready_o(ready), .cmd_done_o(done),
      .cmd_fail_o(fail), .cmd_rdata_o(rdata), .ext_rd_i(ext_rd_i), .ext_addr_i(ext_addr_i),
      .ext_done_o(ext_done), .ext_rdata_o(ext_rdata), .brownout_detect_i(bod_i),
      .brownout_enable_o(bod_en), .brownout_nmi_o(nmi), .config_valid_o(cfg_ok),
      .boot_from_program_o(boot_prog), .flash_secured_o(secured), .debug_enable_o(dbg_en),
      .data_region_enable_o(data_en), .loader_region_on_o(ldr_on),
      .data_base_readback_o(base), .program_region_end_o(prog_end));
   fw_model fw (.core_clk_i(core_clk_i), .ready_i(ready), .done_i(done), .fail_i(fail),
      .rdata_i(rdata), .valid_o(valid), .op_o(op), .addr_o(addr), .wdata_o(wdata));
   task automatic chk(input [31:0] got, input [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input [1:0] o, input [21:0] a, input [31:0] d, input ef);
      logic [31:0] r;
      logic        f;
      fw.run(o, a, d, r, f);
      chk(32'(f), 32'(ef));
   endtask
   task automatic rd(input [21:0] a, input [31:0] e);
      logic [31:0] r;
      logic        f;
      fw.run(`CMD_READ, a, 32'h0, r, f);
      chk(r, e);
   endtask
   task automatic ext(input [21:0] a, input [31:0] e);
      integer n;
      @(posedge core_clk_i);
      ext_rd_i   <= 1'b1;
      ext_addr_i <= a;
      @(negedge core_clk_i);
      for (n = 0; n < 400 && ready !== 1'b1; n++) @(negedge core_clk_i);
      @(posedge core_clk_i);
      ext_rd_i   <= 1'b0;
      ext_addr_i <= ~a;
      @(negedge core_clk_i);
      for (n = 0; n < 400 && ext_done !== 1'b1; n++) @(negedge core_clk_i);
      chk(ext_rdata, e);
   endtask
   task automatic rst();
      @(posedge core_clk_i);
      reset_i <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   task automatic boot(input [31:0] w0, input [31:0] w1);
      wr(`CMD_ERASE, `CFG_WORD0_ADDR, 32'h0, 1'b0);
      wr(`CMD_PROGRAM, `CFG_WORD0_ADDR, w0, 1'b0);
      wr(`CMD_PROGRAM, `CFG_WORD1_ADDR, w1, 1'b0);
      rst();
   endtask
   task automatic brownout_detector(input e);
      @(posedge core_clk_i);
      bod_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(32'(nmi), 32'(e));
      @(posedge core_clk_i);
      bod_i <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400_000;
      fails++;
      $display("BAD at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial begin
      rst();
      boot(32'hFFFF_FF86, 32'h0001_0000);
      chk(32'(cfg_ok), 32'h0000_0001);
      chk(32'({data_en, secured, dbg_en, boot_prog, ldr_on, bod_en}), 32'h2F);
      chk(32'(base), 32'h0001_0000);
      chk(32'(prog_end), 32'h0001_0000);
      wr(`CMD_ERASE, 22'h01_0400, 32'h0, 1'b0);
      rd(22'h01_07FC, `ERASED_WORD);
      wr(`CMD_PROGRAM, 22'h01_0400, 32'hA5A5_F00F, 1'b0);
      wr(`CMD_PROGRAM, 22'h01_0400, 32'h0F0F_FFFF, 1'b0);
      wr(`CMD_PROGRAM, 22'h01_0400, 32'hFFFF_FFFF, 1'b0);
      rd(22'h01_0400, 32'h0505_F00F);
      rd(22'h01_0404, `ERASED_WORD);
      wr(`CMD_ERASE, 22'h01_0400, 32'h0, 1'b0);
      rd(22'h01_0400, `ERASED_WORD);
      wr(`CMD_ERASE, 22'h01_0800, 32'h0, 1'b0);
      wr(`CMD_PROGRAM, 22'h01_0800, 32'h1234_5678, 1'b0);
      ext(22'h01_0800, 32'h1234_5678);
      wr(`CMD_NONE, 22'h01_0800, 32'h0, 1'b1);
      wr(`CMD_PROGRAM, 22'h02_3400, 32'hFFFF_FFFF, 1'b1);
      wr(`CMD_PROGRAM, 22'h10_0000, 32'hFFFF_FFFF, 1'b1);
      brownout_detector(1'b1);
      $display("test open partition done");
      boot(32'hFF7F_FF79, 32'h0001_0000);
      chk(32'(cfg_ok), 32'h0000_0001);
      chk(32'({data_en, secured, dbg_en, boot_prog, ldr_on, bod_en}), 32'h10);
      chk(32'(prog_end), 32'h0002_4400);
      chk(32'(base), 32'h0002_4400);
      rd(22'h01_0800, 32'h1234_5678);
      rd(`CFG_WORD0_ADDR, 32'hFF7F_FF79);
      ext(22'h01_0800, `ERASED_WORD);
      ext(`CFG_WORD0_ADDR, 32'hFF7F_FF79);
      ext(`CFG_WORD1_ADDR, 32'h0001_0000);
      ext(`ID_ADDR, `DEVICE_ID_VALUE);
      wr(`CMD_PROGRAM, 22'h02_3400, 32'hFFFF_FFFF, 1'b0);
      brownout_detector(1'b0);
      $display("test secured done");
      give_verdict();
   end
endmodule // tb_flash_partition_boot_config
